// ==== hw/i2c_port_pkg.sv ====
// Shared constants, tables and types of the serial port control block
package i2c_port_pkg;
  // Register offsets
  localparam logic [7:0] OFS_AUX = 8'h8E;
  localparam logic [7:0] OFS_MODE = 8'h8F;
  localparam logic [7:0] OFS_IRQEN = 8'hA8;
  localparam logic [7:0] OFS_CTRL = 8'hD8;
  localparam logic [7:0] OFS_STAT = 8'hD9;
  localparam logic [7:0] OFS_DATA = 8'hDA;
  localparam logic [7:0] OFS_OWN = 8'hDB;
  // Field positions
  localparam int CTRL_RATE2 = 7;
  localparam int CTRL_ENS = 6;
  localparam int CTRL_STA = 5;
  localparam int CTRL_STO = 4;
  localparam int CTRL_SI = 3;
  localparam int CTRL_AA = 2;
  localparam int CTRL_RATE1 = 1;
  localparam int CTRL_RATE0 = 0;
  localparam int AUX_SRD = 5;
  localparam int AUX_FME = 3;
  localparam int IRQ_GLOBAL = 7;
  localparam int IRQ_PORT = 0;
  localparam int MODE_SIX = 0;
  // Reset values and last bit count
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h8;
  // Status codes, low three bits always zero
  localparam logic [7:0] ST_BUS_ERR = 8'h00;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RESTART = 8'h10;
  localparam logic [7:0] ST_SLAW_ACK = 8'h18;
  localparam logic [7:0] ST_SLAW_NAK = 8'h20;
  localparam logic [7:0] ST_MTX_ACK = 8'h28;
  localparam logic [7:0] ST_MTX_NAK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_SLAR_ACK = 8'h40;
  localparam logic [7:0] ST_SLAR_NAK = 8'h48;
  localparam logic [7:0] ST_MRX_ACK = 8'h50;
  localparam logic [7:0] ST_MRX_NAK = 8'h58;
  localparam logic [7:0] ST_OWN_W = 8'h60;
  localparam logic [7:0] ST_GCALL = 8'h70;
  localparam logic [7:0] ST_SRX_ACK = 8'h80;
  localparam logic [7:0] ST_SRX_NAK = 8'h88;
  localparam logic [7:0] ST_GRX_ACK = 8'h90;
  localparam logic [7:0] ST_GRX_NAK = 8'h98;
  localparam logic [7:0] ST_SLV_STOP = 8'hA0;
  localparam logic [7:0] ST_OWN_R = 8'hA8;
  localparam logic [7:0] ST_STX_ACK = 8'hB8;
  localparam logic [7:0] ST_STX_NAK = 8'hC0;
  localparam logic [7:0] ST_STX_LAST = 8'hC8;
  localparam logic [7:0] ST_NONE = 8'hF8;
  // Oscillator divisors per rate code, 6-clock operation; 12-clock doubles
  localparam logic [7:0][11:0] FAST_DIV = {12'h03C, 12'h050, 12'h640, 12'h078,
                                           12'h00F, 12'h014, 12'h320, 12'h01E};
  localparam logic [7:0][11:0] STD_DIV = {12'h000, 12'h01E, 12'h03C, 12'h1E0,
                                          12'h050, 12'h060, 12'h070, 12'h080};
  localparam logic [2:0] RATE_TIMER = 3'h7;
  // Bus role and master sequencer states
  typedef enum logic [4:0] {
    M_NAS = 5'h01, M_SRX = 5'h02, M_STX = 5'h04, M_MTX = 5'h08, M_MRX = 5'h10
  } role_e;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_START = 4'h2, S_RUN = 4'h4, S_STOP = 4'h8
  } seq_e;
endpackage

// ==== hw/pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_s;
  localparam sync_s RST_S = '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
  sync_s s_ff;
  sync_s nxt_s;

  // First stage feeds only the second; output follows once stages two and three agree
  always_comb begin
    nxt_s.s1 = pin_in;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    nxt_s.q = (~(s_ff.s2 ^ s_ff.s3) & s_ff.s3) | ((s_ff.s2 ^ s_ff.s3) & s_ff.q);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_ff <= RST_S;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pin_q = s_ff.q;
endmodule // pin_sync
`default_nettype wire

// ==== hw/bit_rate_gen.sv ====
// Master bit clock generator: half-bit ticks from the rate code
`timescale 1ns/1ps
`default_nettype none
module bit_rate_gen (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] rate_code,
  input wire logic fast_mode,
  input wire logic six_clock,
  input wire logic ext_tick,
  output logic half_tick
);
  typedef struct packed {
    logic [11:0] cnt;
    logic phase;
    logic tick;
  } div_s;
  div_s s_ff;
  div_s nxt_s;
  logic [11:0] div;
  logic [11:0] full;
  logic [11:0] half;

  // Odd divisors split into a short and a long half so the bit period stays exact
  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    div = fast_mode ? i2c_port_pkg::FAST_DIV[rate_code] : i2c_port_pkg::STD_DIV[rate_code];
    full = six_clock ? div : {div[10:0], 1'b0};
    half = s_ff.phase ? (full - {1'b0, full[11:1]}) : {1'b0, full[11:1]}; // [R14] [R20]
    if (!run) begin
      nxt_s.cnt = '0;
      nxt_s.phase = 1'b0;
    end else if (!fast_mode && rate_code == i2c_port_pkg::RATE_TIMER) begin
      nxt_s.tick = ext_tick; // Timer-derived rate in standard mode
    end else if (s_ff.cnt + 12'h001 >= half) begin
      nxt_s.cnt = '0;
      nxt_s.phase = ~s_ff.phase;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign half_tick = s_ff.tick;
endmodule // bit_rate_gen
`default_nettype wire

// ==== hw/i2c_port_control.sv ====
// Byte-oriented serial bus port: registers, bus monitor, slave and master control
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] Stop then start when both requested
// [R2] Interrupt when event flag and both enables
// [R3] Event flag set on every state except F8H
// [R4] Hold clock low while event flag set
// [R5] Software alone clears the event flag
// [R6] Acknowledge own address, call, received data
// [R7] Not-acknowledge received data when ack flag clear
// [R8] Last transmitted byte gives C8H, then unaddressed
// [R9] Software may re-arm acknowledge flag in C8H
// [R10] Unaddressed: ignore addresses, no ack, no interrupt
// [R11] Released port still tracks bus and shifts; code shifts but clears busy and bit count while disabled
// [R12] Late acknowledge flag still recognises address
// [R13] Rate code matters only as master
// [R14] Fast mode divisors per rate code
// [R15] Fast mode one-shot set, reset clears
// [R16] Slew disable bit, read/write, resets clear
// [R17] Status holds code, low bits zero
// [R18] Status valid around event flag window
// [R19] Own address upper bits, bit0 general call
// [R20] 12-clock fast divisors double 6-clock ones
module i2c_port_control (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic rate_ext_tick,
  output logic serial_irq_req,
  output logic slew_control_disable
);
  typedef struct packed {
    logic si;
    logic start_request_flag;
    logic stop_request_flag;
    logic assert_ack_flag;
    logic port_enable;
    logic [2:0] rate;
    logic [7:0] own;
    logic [7:0] shift;
    logic global_irq_enable;
    logic port_irq_enable;
    logic six_clock;
    logic fast_mode_enable;
    logic slew_off;
    logic [7:0] status;
    logic si_d;
    i2c_port_pkg::role_e mode;
    i2c_port_pkg::seq_e st;
    logic [1:0] step;
    logic [3:0] cnt;
    logic first;
    logic busy;
    logic ack_low;
    logic gc_hit;
    logic sda_low;
    logic scl_m_low;
    logic scl_hold;
    logic scl_p;
    logic sda_p;
    logic [7:0] rdata;
  } port_s;
  localparam port_s RST_S = '{mode: i2c_port_pkg::M_NAS, st: i2c_port_pkg::S_IDLE,
                              own: i2c_port_pkg::OWN_RST, shift: i2c_port_pkg::DATA_RST,
                              status: i2c_port_pkg::ST_NONE, scl_p: 1'b1, sda_p: 1'b1,
                              default: '0};
  port_s s_ff;
  port_s nxt_s;
  logic [1:0] pins_q;
  logic scl_s;
  logic sda_s;
  logic half_tick;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic is_tx;
  logic is_mst;
  logic hw_set;
  logic [7:0] hw_code;
  logic [7:0] nb;
  logic addr_hit;

  pin_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({scl_in, sda_in}),
    .pin_q(pins_q)
  );
  assign scl_s = pins_q[1];
  assign sda_s = pins_q[0];

  // Rate code only drives the clock while this end is master
  bit_rate_gen u_rate (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(s_ff.st != i2c_port_pkg::S_IDLE), // [R13]
    .rate_code(s_ff.rate),
    .fast_mode(s_ff.fast_mode_enable),
    .six_clock(s_ff.six_clock),
    .ext_tick(rate_ext_tick),
    .half_tick(half_tick)
  );

  // Bus edge and condition detection on filtered pins
  assign scl_rise = scl_s & ~s_ff.scl_p;
  assign scl_fall = ~scl_s & s_ff.scl_p;
  assign start_ev = scl_s & s_ff.scl_p & ~sda_s & s_ff.sda_p;
  assign stop_ev = scl_s & s_ff.scl_p & sda_s & ~s_ff.sda_p;
  assign is_tx = (s_ff.mode == i2c_port_pkg::M_MTX) || (s_ff.mode == i2c_port_pkg::M_STX);
  assign is_mst = (s_ff.mode == i2c_port_pkg::M_MTX) || (s_ff.mode == i2c_port_pkg::M_MRX);
  assign nb = {s_ff.shift[6:0], sda_s};
  // Acknowledge flag checked at byte end, so a late set still matches
  assign addr_hit = s_ff.assert_ack_flag && ((nb[7:1] == s_ff.own[7:1]) || (nb == 8'h00 && s_ff.own[0])); // [R12] [R19]

  always_comb begin
    nxt_s = s_ff;
    hw_set = 1'b0;
    hw_code = i2c_port_pkg::ST_NONE;
    nxt_s.scl_p = scl_s;
    nxt_s.sda_p = sda_s;
    nxt_s.si_d = s_ff.si;
    nxt_s.rdata = 8'h00;
    // Register reads, answered in the next cycle
    if (rd_en) begin
      case (addr)
        i2c_port_pkg::OFS_CTRL: nxt_s.rdata = {s_ff.rate[2], s_ff.port_enable, s_ff.start_request_flag,
                                               s_ff.stop_request_flag, s_ff.si, s_ff.assert_ack_flag,
                                               s_ff.rate[1:0]};
        i2c_port_pkg::OFS_STAT: nxt_s.rdata = (s_ff.si || s_ff.si_d) ? s_ff.status : i2c_port_pkg::ST_NONE; // [R17] [R18]
        i2c_port_pkg::OFS_DATA: nxt_s.rdata = s_ff.shift;
        i2c_port_pkg::OFS_OWN: nxt_s.rdata = s_ff.own;
        i2c_port_pkg::OFS_AUX: begin
          nxt_s.rdata[i2c_port_pkg::AUX_SRD] = s_ff.slew_off;
          nxt_s.rdata[i2c_port_pkg::AUX_FME] = s_ff.fast_mode_enable;
        end
        i2c_port_pkg::OFS_IRQEN: begin
          nxt_s.rdata[i2c_port_pkg::IRQ_GLOBAL] = s_ff.global_irq_enable;
          nxt_s.rdata[i2c_port_pkg::IRQ_PORT] = s_ff.port_irq_enable;
        end
        i2c_port_pkg::OFS_MODE: nxt_s.rdata[i2c_port_pkg::MODE_SIX] = s_ff.six_clock;
        default: nxt_s.rdata = 8'h00;
      endcase
    end
    // Register writes; event flag can only be cleared from here
    if (wr_en) begin
      case (addr)
        i2c_port_pkg::OFS_CTRL: begin
          nxt_s.rate = {wr_data[i2c_port_pkg::CTRL_RATE2], wr_data[i2c_port_pkg::CTRL_RATE1],
                        wr_data[i2c_port_pkg::CTRL_RATE0]};
          nxt_s.port_enable = wr_data[i2c_port_pkg::CTRL_ENS];
          nxt_s.start_request_flag = wr_data[i2c_port_pkg::CTRL_STA];
          nxt_s.stop_request_flag = wr_data[i2c_port_pkg::CTRL_STO];
          nxt_s.assert_ack_flag = wr_data[i2c_port_pkg::CTRL_AA]; // [R9]
          if (!wr_data[i2c_port_pkg::CTRL_SI]) begin
            nxt_s.si = 1'b0; // [R5]
          end
        end
        i2c_port_pkg::OFS_DATA: begin
          nxt_s.shift = wr_data;
          if (is_tx) begin
            nxt_s.sda_low = ~wr_data[7]; // First bit goes out at once
          end
        end
        i2c_port_pkg::OFS_OWN: nxt_s.own = wr_data;
        i2c_port_pkg::OFS_AUX: begin
          nxt_s.slew_off = wr_data[i2c_port_pkg::AUX_SRD]; // [R16]
          nxt_s.fast_mode_enable = s_ff.fast_mode_enable | wr_data[i2c_port_pkg::AUX_FME]; // [R15]
        end
        i2c_port_pkg::OFS_IRQEN: begin
          nxt_s.global_irq_enable = wr_data[i2c_port_pkg::IRQ_GLOBAL];
          nxt_s.port_irq_enable = wr_data[i2c_port_pkg::IRQ_PORT];
        end
        i2c_port_pkg::OFS_MODE: nxt_s.six_clock = wr_data[i2c_port_pkg::MODE_SIX];
        default: ;
      endcase
    end
    // Bus monitor runs in every role, including when released
    if (scl_rise && s_ff.cnt != i2c_port_pkg::BIT_LAST) begin
      nxt_s.shift = nb; // [R11]
      nxt_s.cnt = s_ff.cnt + 4'h1;
      if (is_mst && is_tx && !s_ff.sda_low && !sda_s) begin
        nxt_s.mode = i2c_port_pkg::M_NAS; // Lost arbitration, drop off and raise the event flag with 38H
        nxt_s.st = i2c_port_pkg::S_IDLE;
        nxt_s.scl_m_low = 1'b0;
        hw_set = 1'b1;
        hw_code = i2c_port_pkg::ST_ARB_LOST;
      end else if (s_ff.cnt == 4'h7) begin
        if (s_ff.first && !is_mst) begin
          nxt_s.ack_low = addr_hit; // [R6] [R10]
          nxt_s.gc_hit = (nb == 8'h00);
        end else if (s_ff.mode == i2c_port_pkg::M_MRX || s_ff.mode == i2c_port_pkg::M_SRX) begin
          nxt_s.ack_low = s_ff.assert_ack_flag; // [R6] [R7]
        end else begin
          nxt_s.ack_low = 1'b0;
        end
      end
    end else if (scl_rise) begin
      // Ninth clock: acknowledge seen, byte closes
      nxt_s.cnt = 4'h0;
      nxt_s.first = 1'b0;
      case (s_ff.mode)
        i2c_port_pkg::M_MTX: begin
          hw_set = 1'b1;
          if (s_ff.first && s_ff.shift[0]) begin
            hw_code = sda_s ? i2c_port_pkg::ST_SLAR_NAK : i2c_port_pkg::ST_SLAR_ACK;
            nxt_s.mode = sda_s ? i2c_port_pkg::M_MTX : i2c_port_pkg::M_MRX;
          end else if (s_ff.first) begin
            hw_code = sda_s ? i2c_port_pkg::ST_SLAW_NAK : i2c_port_pkg::ST_SLAW_ACK;
          end else begin
            hw_code = sda_s ? i2c_port_pkg::ST_MTX_NAK : i2c_port_pkg::ST_MTX_ACK;
          end
        end
        i2c_port_pkg::M_MRX: begin
          hw_set = 1'b1;
          hw_code = sda_s ? i2c_port_pkg::ST_MRX_NAK : i2c_port_pkg::ST_MRX_ACK;
        end
        i2c_port_pkg::M_SRX: begin
          hw_set = 1'b1;
          if (s_ff.gc_hit) begin
            hw_code = sda_s ? i2c_port_pkg::ST_GRX_NAK : i2c_port_pkg::ST_GRX_ACK;
          end else begin
            hw_code = sda_s ? i2c_port_pkg::ST_SRX_NAK : i2c_port_pkg::ST_SRX_ACK;
          end
          if (sda_s) begin
            nxt_s.mode = i2c_port_pkg::M_NAS;
          end
        end
        i2c_port_pkg::M_STX: begin
          hw_set = 1'b1;
          if (sda_s) begin
            hw_code = i2c_port_pkg::ST_STX_NAK;
            nxt_s.mode = i2c_port_pkg::M_NAS;
          end else if (!s_ff.assert_ack_flag) begin
            hw_code = i2c_port_pkg::ST_STX_LAST; // [R8]
            nxt_s.mode = i2c_port_pkg::M_NAS;
          end else begin
            hw_code = i2c_port_pkg::ST_STX_ACK;
          end
        end
        default: begin
          // Unaddressed: only a matched address wakes the slave
          if (s_ff.first && s_ff.ack_low) begin // [R10]
            hw_set = 1'b1;
            if (s_ff.gc_hit) begin
              hw_code = i2c_port_pkg::ST_GCALL;
              nxt_s.mode = i2c_port_pkg::M_SRX;
            end else if (s_ff.shift[0]) begin
              hw_code = i2c_port_pkg::ST_OWN_R;
              nxt_s.mode = i2c_port_pkg::M_STX;
            end else begin
              hw_code = i2c_port_pkg::ST_OWN_W;
              nxt_s.mode = i2c_port_pkg::M_SRX;
            end
          end
        end
      endcase
    end
    // Data changes only while the clock is low
    if (scl_fall) begin
      if (s_ff.cnt == i2c_port_pkg::BIT_LAST) begin
        nxt_s.sda_low = s_ff.ack_low; // [R6] [R7]
      end else if (s_ff.cnt == 4'h0) begin
        if (s_ff.ack_low) begin
          nxt_s.sda_low = 1'b0;
          nxt_s.ack_low = 1'b0;
        end
      end else begin
        nxt_s.sda_low = is_tx & ~s_ff.shift[7];
      end
    end
    if (start_ev) begin
      nxt_s.busy = 1'b1;
      nxt_s.cnt = 4'h0;
      nxt_s.first = 1'b1;
      nxt_s.ack_low = 1'b0;
      if (s_ff.mode == i2c_port_pkg::M_SRX || s_ff.mode == i2c_port_pkg::M_STX) begin
        nxt_s.mode = i2c_port_pkg::M_NAS;
        hw_set = 1'b1;
        hw_code = i2c_port_pkg::ST_SLV_STOP;
      end
    end
    if (stop_ev) begin
      nxt_s.busy = 1'b0;
      nxt_s.cnt = 4'h0;
      nxt_s.first = 1'b0;
      nxt_s.stop_request_flag = 1'b0;
      nxt_s.mode = i2c_port_pkg::M_NAS;
      if (s_ff.mode == i2c_port_pkg::M_SRX || s_ff.mode == i2c_port_pkg::M_STX) begin
        hw_set = 1'b1;
        hw_code = i2c_port_pkg::ST_SLV_STOP;
      end
    end
    // Held-low clock is only grabbed once it is already low
    nxt_s.scl_hold = s_ff.si & (~scl_s | s_ff.scl_hold); // [R4]
    // Master sequencer, stepped by half-bit ticks
    case (s_ff.st)
      i2c_port_pkg::S_IDLE: begin
        if (s_ff.stop_request_flag && !s_ff.si) begin
          nxt_s.stop_request_flag = 1'b0; // [R1]
          nxt_s.mode = i2c_port_pkg::M_NAS;
        end else if (s_ff.start_request_flag && !s_ff.busy && !s_ff.si) begin
          nxt_s.st = i2c_port_pkg::S_START;
          nxt_s.step = 2'h0;
        end
      end
      i2c_port_pkg::S_START: begin
        if (half_tick) begin
          case (s_ff.step)
            2'h0: begin
              nxt_s.sda_low = 1'b0;
              nxt_s.step = 2'h1;
            end
            2'h1: begin
              nxt_s.scl_m_low = 1'b0;
              if (scl_s) begin
                nxt_s.step = 2'h2;
              end
            end
            2'h2: begin
              nxt_s.sda_low = 1'b1;
              nxt_s.step = 2'h3;
            end
            default: begin
              nxt_s.scl_m_low = 1'b1;
              nxt_s.mode = i2c_port_pkg::M_MTX;
              nxt_s.st = i2c_port_pkg::S_RUN;
              hw_set = 1'b1;
              hw_code = is_mst ? i2c_port_pkg::ST_RESTART : i2c_port_pkg::ST_START;
            end
          endcase
        end
      end
      i2c_port_pkg::S_RUN: begin
        if (!s_ff.si && s_ff.cnt == 4'h0 && s_ff.scl_m_low && s_ff.stop_request_flag) begin
          nxt_s.st = i2c_port_pkg::S_STOP; // [R1]
          nxt_s.step = 2'h0;
        end else if (!s_ff.si && s_ff.cnt == 4'h0 && s_ff.scl_m_low && s_ff.start_request_flag) begin
          nxt_s.st = i2c_port_pkg::S_START;
          nxt_s.step = 2'h0;
        end else if (half_tick && s_ff.scl_m_low && !s_ff.si) begin
          nxt_s.scl_m_low = 1'b0; // Suspended while the event flag stands
        end else if (half_tick && !s_ff.scl_m_low && scl_s) begin
          nxt_s.scl_m_low = 1'b1; // Waits out any slave stretching
        end
      end
      i2c_port_pkg::S_STOP: begin
        if (half_tick) begin
          case (s_ff.step)
            2'h0: begin
              nxt_s.sda_low = 1'b1;
              nxt_s.step = 2'h1;
            end
            2'h1: begin
              nxt_s.scl_m_low = 1'b0;
              if (scl_s) begin
                nxt_s.step = 2'h2;
              end
            end
            default: begin
              nxt_s.sda_low = 1'b0;
              nxt_s.stop_request_flag = 1'b0;
              nxt_s.mode = i2c_port_pkg::M_NAS;
              nxt_s.st = i2c_port_pkg::S_IDLE; // Pending start follows from idle
            end
          endcase
        end
      end
      default: nxt_s.st = i2c_port_pkg::S_IDLE;
    endcase
    // Hardware set beats a same-cycle software clear
    if (hw_set && hw_code != i2c_port_pkg::ST_NONE) begin
      nxt_s.si = 1'b1; // [R3]
      nxt_s.status = hw_code;
    end
    // Disabled port floats the pins and loses the bus state
    if (!s_ff.port_enable) begin
      nxt_s.stop_request_flag = 1'b0;
      nxt_s.mode = i2c_port_pkg::M_NAS;
      nxt_s.st = i2c_port_pkg::S_IDLE;
      nxt_s.sda_low = 1'b0;
      nxt_s.scl_m_low = 1'b0;
      nxt_s.scl_hold = 1'b0;
      nxt_s.ack_low = 1'b0;
      nxt_s.cnt = 4'h0;
      nxt_s.first = 1'b0;
      nxt_s.busy = 1'b0;
      nxt_s.si = (wr_en && addr == i2c_port_pkg::OFS_CTRL) ? nxt_s.si : s_ff.si;
      nxt_s.status = s_ff.status;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_ff <= RST_S;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Open-drain pins: only the enables toggle
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = s_ff.scl_m_low | s_ff.scl_hold; // [R4]
  assign sda_oe = s_ff.sda_low;
  assign rd_data = s_ff.rdata;
  assign serial_irq_req = s_ff.si & s_ff.global_irq_enable & s_ff.port_irq_enable; // [R2]
  assign slew_control_disable = s_ff.slew_off; // [R16]
endmodule // i2c_port_control
`default_nettype wire

// ==== testbench/i2c_port_control_checker.sv ====
// Port-level assertions for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module i2c_port_control_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic serial_irq_req,
  input wire logic slew_control_disable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Register access in the previous cycle, the cause of most outputs
  sequence rd_of(logic [7:0] a);
    $past(rd_en) && $past(addr) == a;
  endsequence
  sequence wr_of(logic [7:0] a);
    $past(wr_en) && $past(addr) == a;
  endsequence
  chk_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_slew_write: assert property (wr_of(8'h8E) |-> slew_control_disable == $past(wr_data[5]))
    else $error("slew disable does not follow write");
  chk_slew_read: assert property (rd_of(8'h8E) |-> rd_data[5] == slew_control_disable)
    else $error("slew disable read back differs from pin");
  chk_status_low_zero: assert property (rd_of(8'hD9) |-> rd_data[2:0] == 3'h0)
    else $error("status low bits not zero");
  // Slack of five cycles: four synchroniser flops plus the hold flop
  chk_stretch_hold: assert property (serial_irq_req && !scl_in |-> ##[0:5] (scl_oe || !serial_irq_req))
    else $error("clock not held low while event pending");
  chk_irq_mask: assert property (wr_of(8'hA8) |-> !serial_irq_req || ($past(wr_data[7]) && $past(wr_data[0])))
    else $error("interrupt request despite cleared enable");
  chk_flag_sw_clear: assert property ($fell(serial_irq_req) |-> $past(wr_en))
    else $error("event flag cleared without a write");
  chk_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin driven high");
endmodule // i2c_port_control_checker
bind i2c_port_control i2c_port_control_checker chk (.clk_sys, .rst, .addr, .wr_data, .wr_en, .rd_en,
  .rd_data, .scl_in, .scl_out, .scl_oe, .sda_out, .serial_irq_req, .slew_control_disable);
`default_nettype wire

// ==== testbench/i2c_master_model.sv ====
// Behavioural bus master on the far side: start, address byte, stop
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic clk_sys,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  // Both lines released at time zero, bus idle
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Third of a bit, slow enough for the pin synchroniser
  task automatic q();
    repeat (10) @(posedge clk_sys);
  endtask
  // Start then one byte MSB first; ack is true when SDA low at the ninth pulse
  task automatic frame(input logic [7:0] b, output logic ack);
    sda_low <= 1'b1;
    q();
    scl_low <= 1'b1;
    q();
    for (int i = 7; i >= 0; i--) begin
      sda_low <= !b[i];
      q();
      scl_low <= 1'b0;
      q();
      scl_low <= 1'b1;
      q();
    end
    sda_low <= 1'b0;
    q();
    scl_low <= 1'b0;
    q();
    ack = !sda;
    scl_low <= 1'b1;
    q();
    scl_low <= 1'b0;
    q();
  endtask
  // Stop; waits, bounded, while the port still stretches the clock
  task automatic stop();
    scl_low <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl_low <= 1'b0;
    for (int n = 0; n < 40 && !scl; n++) @(posedge clk_sys);
    q();
    sda_low <= 1'b0;
    q();
  endtask
endmodule // i2c_master_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Testbench: register tasks and addressed slave phases against a bus master model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys, rst, wr_en, rd_en, m_scl_low, m_sda_low, ack;
  logic [7:0] addr, wr_data, rd_data;
  logic scl_out, scl_oe, sda_out, sda_oe, serial_irq_req, slew_control_disable;
  int bad_count, samples_checked;
  // Pull-ups: a line is low only while some party pulls it
  wire logic scl = !(scl_oe || m_scl_low);
  wire logic sda = !(sda_oe || m_sda_low);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  i2c_port_control dut (.clk_sys, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .scl_in(scl), .scl_out,
    .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .rate_ext_tick(1'b0), .serial_irq_req, .slew_control_disable);
  i2c_master_model m (.clk_sys, .scl, .sda, .scl_low(m_scl_low), .sda_low(m_sda_low));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Leading edge keeps strobes of back-to-back calls apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk(n, e, rd_data);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, far above the under two thousand cycles of the run
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    close_out();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rc(8'h8E, 8'h00, "aux reset");
    rc(8'hD9, 8'hF8, "status reset");
    rc(8'h55, 8'h00, "unmapped read");
    wr(8'h8E, 8'h28);
    rc(8'h8E, 8'h28, "aux set");
    chk("slew pin", 8'h01, 8'(slew_control_disable));
    wr(8'h8E, 8'h00);
    rc(8'h8E, 8'h08, "fast mode kept");
    chk("slew pin off", 8'h00, 8'(slew_control_disable));
    wr(8'hDB, 8'hA1);
    wr(8'hA8, 8'h81);
    wr(8'hD8, 8'h40);
    m.frame(8'hA0, ack);
    #1 chk("unaddressed ack", 8'h00, 8'(ack));
    chk("no stretch", 8'h01, 8'(scl));
    chk("no irq", 8'h00, 8'(serial_irq_req));
    m.stop();
    chk("bus free", 8'h01, 8'(scl));
    wr(8'hD8, 8'h44);
    // Own address, then general call
    for (int i = 0; i < 2; i++) begin
      m.frame(i ? 8'h00 : 8'hA0, ack);
      #1 chk("ack", 8'h01, 8'(ack));
      chk("stretch", 8'h00, 8'(scl));
      chk("irq", 8'h01, 8'(serial_irq_req));
      rc(8'hD9, i ? i2c_port_pkg::ST_GCALL : i2c_port_pkg::ST_OWN_W, "status");
      wr(8'hA8, 8'h01);
      #1 chk("irq masked", 8'h00, 8'(serial_irq_req));
      wr(8'hA8, 8'h81);
      wr(8'hD8, 8'h44);
      m.stop();
      chk("bus free", 8'h01, 8'(scl));
      rc(8'hD9, i2c_port_pkg::ST_SLV_STOP, "stop status");
      wr(8'hD8, 8'h44);
      rc(8'hD9, 8'hF8, "status idle");
    end
    // Own start, then stop and start together; two edges pass before the flag is polled
    for (int i = 0; i < 2; i++) begin
      wr(8'hD8, i ? 8'h70 : 8'h60);
      for (int n = 0; n < 600 && (n < 2 || !serial_irq_req); n++) @(posedge clk_sys);
      chk("start irq", 8'h01, 8'(serial_irq_req));
      rc(8'hD9, i2c_port_pkg::ST_START, "start status");
    end
    wr(8'hD8, 8'h50);
    repeat (250) @(posedge clk_sys);
    rc(8'hD8, 8'h40, "stop flag cleared");
    close_out();
  end
endmodule // testbench
`default_nettype wire
